// ==== hw/asfl_core.sv ====
// Status flag generator with main and alternate flag bytes on a Wishbone slave
`timescale 1ns/1ps
`include "asfl_defines.svh"

module asfl_core
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire asfl_pkg::asfl_wb_req_t wb_req_i,
  output asfl_pkg::asfl_wb_rsp_t wb_rsp_o,
  output asfl_pkg::asfl_cond_t cond_o,
  output logic [7:0] result_o
);
  import asfl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  asfl_flags_t main_condition_flags;
  asfl_flags_t alternate_condition_flags;
  logic [15:0] opctl;
  logic [15:0] operand;
  logic op_go;
  logic ack;
  logic [31:0] rdata;
  logic [7:0] result;
  asfl_cond_t cond;

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = wb_req_i.cyc && wb_req_i.stb && !ack;
  wire bus_wr = bus_req && wb_req_i.we;
  wire hit_main = wb_req_i.adr == `ASFL_OFS_MAIN;
  wire hit_alt = wb_req_i.adr == `ASFL_OFS_ALT;
  wire hit_opctl = wb_req_i.adr == `ASFL_OFS_OPCTL;
  wire hit_operand = wb_req_i.adr == `ASFL_OFS_OPERAND;
  wire [7:0] wr_lo = wb_req_i.sel[0] ? wb_req_i.dat[7:0] : 8'h00;
  wire [31:0] next_rdata =
    hit_main ? {24'h000000, main_condition_flags} :
    hit_alt ? {24'h000000, alternate_condition_flags} :
    hit_opctl ? {16'h0000, opctl} :
    hit_operand ? {16'h0000, operand} : 32'h00000000;
  wire wr_opctl = bus_wr && hit_opctl;
  wire [15:0] next_opctl = {
    wb_req_i.sel[1] ? wb_req_i.dat[15:8] : opctl[15:8],
    wb_req_i.sel[0] ? wb_req_i.dat[7:0] : opctl[7:0]};
  wire [15:0] next_operand = {
    wb_req_i.sel[1] ? wb_req_i.dat[15:8] : operand[15:8],
    wb_req_i.sel[0] ? wb_req_i.dat[7:0] : operand[7:0]};

  // ****************************************
  // Operation fields
  // ****************************************
  wire asfl_op_t op = asfl_op_t'(opctl[`ASFL_OPCTL_OP_MSB:`ASFL_OPCTL_OP_LSB]);
  wire [2:0] bit_sel = opctl[`ASFL_OPCTL_BITSEL_MSB:`ASFL_OPCTL_BITSEL_LSB];
  wire interrupt_enable_copy = opctl[`ASFL_OPCTL_IEC];
  wire count_zero = opctl[`ASFL_OPCTL_CNTZ];
  wire dadj_extra_carry = opctl[`ASFL_OPCTL_DAAC];
  wire swap_req = opctl[`ASFL_OPCTL_SWAP];
  wire [7:0] acc = operand[7:0];
  wire [7:0] opb = operand[15:8];
  wire cin = main_condition_flags.carry;

  // ****************************************
  // Adder with carries at bit 4 and bit 7
  // ****************************************
  wire is_sub = op == ASFL_OP_SUB || op == ASFL_OP_SBC || op == ASFL_OP_CMP || op == ASFL_OP_BLKSRCH;
  wire use_cin = op == ASFL_OP_ADC || op == ASFL_OP_SBC;
  wire [7:0] addend = is_sub ? ~opb : opb;
  wire c0 = is_sub ^ (use_cin & cin);
  wire [4:0] lo_sum = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, c0};
  wire [3:0] mid_sum = {1'b0, acc[6:4]} + {1'b0, addend[6:4]} + {3'h0, lo_sum[4]};
  wire [1:0] top_sum = {1'b0, acc[7]} + {1'b0, addend[7]} + {1'b0, mid_sum[3]};
  wire [7:0] sum = {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
  wire carry_out = top_sum[1] ^ is_sub;
  wire half_out = lo_sum[4] ^ is_sub;
  wire ovf = mid_sum[3] ^ top_sum[1];

  // ****************************************
  // Rotate and shift unit
  // ****************************************
  logic [7:0] rot;
  logic rot_c;
  always_comb
  begin
    rot = acc;
    rot_c = cin;
    case (op)
      ASFL_OP_ROT_LEFT_CIRC:
      begin
        rot = {acc[6:0], acc[7]};
        rot_c = acc[7];
      end
      ASFL_OP_SHIFT_LEFT_ARITH:
      begin
        rot = {acc[6:0], 1'b0};
        rot_c = acc[7];
      end
      ASFL_OP_ROT_RIGHT_CIRC:
      begin
        rot = {acc[0], acc[7:1]};
        rot_c = acc[0];
      end
      ASFL_OP_SHIFT_RIGHT_ARITH:
      begin
        rot = {acc[7], acc[7:1]};
        rot_c = acc[0];
      end
      ASFL_OP_SHIFT_RIGHT_LOG:
      begin
        rot = {1'b0, acc[7:1]};
        rot_c = acc[0];
      end
      ASFL_OP_RL:
      begin
        rot = {acc[6:0], cin};
        rot_c = acc[7];
      end
      ASFL_OP_RR:
      begin
        rot = {cin, acc[7:1]};
        rot_c = acc[0];
      end
      default:
      begin
        rot = acc;
        rot_c = cin;
      end
    endcase
  end

  // ****************************************
  // Decimal adjust
  // ****************************************
  wire dadj_lo = main_condition_flags.half || (acc[3:0] > 4'h9);
  wire dadj_hi = cin || (acc > 8'h99);
  wire [7:0] dadj_fix = {dadj_hi ? 4'h6 : 4'h0, dadj_lo ? 4'h6 : 4'h0};
  wire [7:0] dadj_res = main_condition_flags.sub ? acc - dadj_fix : acc + dadj_fix;
  wire dadj_half = main_condition_flags.sub ? (main_condition_flags.half && acc[3:0] < 4'h6)
                                            : (acc[3:0] > 4'h9);

  // ****************************************
  // Flag computation
  // ****************************************
  logic [7:0] res;
  asfl_flags_t nf;
  always_comb
  begin
    res = acc;
    nf = main_condition_flags;
    case (op)
      ASFL_OP_ADD, ASFL_OP_ADC, ASFL_OP_SUB, ASFL_OP_SBC, ASFL_OP_CMP:
      begin
        res = (op == ASFL_OP_CMP) ? acc : sum;
        nf.sign = sum[7];
        nf.zero = sum == 8'h00;
        nf.half = half_out;
        nf.par_ovf = ovf;
        nf.sub = is_sub;
        nf.carry = carry_out;
      end
      ASFL_OP_AND, ASFL_OP_OR, ASFL_OP_XOR:
      begin
        res = op == ASFL_OP_AND ? acc & opb : op == ASFL_OP_OR ? acc | opb : acc ^ opb;
        nf.sign = res[7];
        nf.zero = res == 8'h00;
        nf.half = op == ASFL_OP_AND;
        nf.par_ovf = ~^res;
        nf.sub = 1'b0;
        nf.carry = 1'b0;
      end
      ASFL_OP_ROT_LEFT_CIRC, ASFL_OP_ROT_RIGHT_CIRC, ASFL_OP_RL, ASFL_OP_RR,
      ASFL_OP_SHIFT_LEFT_ARITH, ASFL_OP_SHIFT_RIGHT_ARITH, ASFL_OP_SHIFT_RIGHT_LOG:
      begin
        res = rot;
        nf.sign = rot[7];
        nf.zero = rot == 8'h00;
        nf.half = 1'b0;
        nf.par_ovf = ~^rot;
        nf.sub = 1'b0;
        nf.carry = rot_c;
      end
      ASFL_OP_DEC_ADJUST:
      begin
        res = dadj_res;
        nf.sign = dadj_res[7];
        nf.zero = dadj_res == 8'h00;
        nf.half = dadj_half;
        nf.par_ovf = ~^dadj_res;
        nf.carry = dadj_hi | dadj_extra_carry;
      end
      ASFL_OP_SET_CARRY:
      begin
        nf.half = 1'b0;
        nf.sub = 1'b0;
        nf.carry = 1'b1;
      end
      ASFL_OP_CPL_CARRY:
      begin
        nf.half = cin;
        nf.sub = 1'b0;
        nf.carry = ~cin;
      end
      ASFL_OP_BIT:
      begin
        nf.zero = ~acc[bit_sel];
        nf.half = 1'b1;
        nf.sub = 1'b0;
      end
      ASFL_OP_BLKXFER:
      begin
        nf.par_ovf = ~count_zero;
        nf.half = 1'b0;
        nf.sub = 1'b0;
      end
      ASFL_OP_BLKSRCH:
      begin
        nf.sign = sum[7];
        nf.zero = acc == opb;
        nf.half = half_out;
        nf.par_ovf = ~count_zero;
        nf.sub = 1'b1;
      end
      ASFL_OP_BLKIO:
      begin
        nf.zero = count_zero;
        nf.sub = 1'b1;
      end
      ASFL_OP_PORTIN:
      begin
        nf.sign = acc[7];
        nf.zero = acc == 8'h00;
        nf.par_ovf = ~^acc;
        nf.half = 1'b0;
        nf.sub = 1'b0;
      end
      ASFL_OP_LDIRQ:
      begin
        nf.sign = acc[7];
        nf.zero = acc == 8'h00;
        nf.par_ovf = interrupt_enable_copy;
        nf.half = 1'b0;
        nf.sub = 1'b0;
      end
      default:
      begin
        res = acc;
        nf = main_condition_flags;
      end
    endcase
    nf.und5 = 1'b0;
    nf.und3 = 1'b0;
  end

  // ****************************************
  // Registers
  // ****************************************
  wire [7:0] wr_flags = wr_lo & `ASFL_FLAG_MASK;
  wire asfl_cond_t next_cond = '{c: nf.carry, pv: nf.par_ovf, z: nf.zero, s: nf.sign};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_condition_flags <= `ASFL_FLAGS_RST;
      alternate_condition_flags <= `ASFL_FLAGS_RST;
      opctl <= 16'h0000;
      operand <= 16'h0000;
      op_go <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h00000000;
      result <= 8'h00;
      cond <= '0;
    end
    else
    begin
      ack <= bus_req;
      rdata <= bus_req && !wb_req_i.we ? next_rdata : 32'h00000000;
      op_go <= wr_opctl;
      if (wr_opctl)
        opctl <= next_opctl;
      if (bus_wr && hit_operand)
        operand <= next_operand;
      if (op_go && swap_req)
      begin
        main_condition_flags <= alternate_condition_flags;
        alternate_condition_flags <= main_condition_flags;
      end
      else if (op_go)
      begin
        main_condition_flags <= nf;
        result <= res;
        cond <= next_cond;
      end
      else if (bus_wr && hit_main && wb_req_i.sel[0])
        main_condition_flags <= wr_flags;
      else if (bus_wr && hit_alt && wb_req_i.sel[0])
        alternate_condition_flags <= wr_flags;
    end
  end

  assign wb_rsp_o = '{ack: ack, dat: rdata};
  assign cond_o = cond;
  assign result_o = result;

  // ****************************************
  // Checks
  // ****************************************
  a_logic_carry_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op inside {ASFL_OP_AND, ASFL_OP_OR, ASFL_OP_XOR} |=> !main_condition_flags.carry)
    else $error("logic op left carry set");
  a_set_carry_one: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op == ASFL_OP_SET_CARRY |=> main_condition_flags.carry)
    else $error("set carry failed");
  a_cpl_carry_inv: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op == ASFL_OP_CPL_CARRY |=> main_condition_flags.carry != $past(cin))
    else $error("complement carry failed");
  a_sub_bit_set: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op inside {ASFL_OP_SUB, ASFL_OP_SBC, ASFL_OP_CMP} |=> main_condition_flags.sub)
    else $error("subtract bit not set");
  a_add_carry_out: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op == ASFL_OP_ADD |=>
      main_condition_flags.carry == ({1'b0, $past(acc)} + {1'b0, $past(opb)} > 9'h0ff))
    else $error("add carry wrong");
  a_bit_test_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op == ASFL_OP_BIT |=> main_condition_flags.zero == !$past(acc[bit_sel]))
    else $error("bit test zero wrong");
  a_undef_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !main_condition_flags.und3 && !main_condition_flags.und5
      && !alternate_condition_flags.und3 && !alternate_condition_flags.und5)
    else $error("undefined flag bit set");
  a_swap_copies: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && swap_req |=> main_condition_flags == $past(alternate_condition_flags)
      && alternate_condition_flags == $past(main_condition_flags))
    else $error("flag swap wrong");
  a_portin_parity: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req && op == ASFL_OP_PORTIN |=> main_condition_flags.par_ovf == ~^$past(acc))
    else $error("port input parity wrong");
  a_cond_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    op_go && !swap_req |=> cond_o.c == main_condition_flags.carry && cond_o.z == main_condition_flags.zero)
    else $error("condition outputs stale");

endmodule // asfl_core

// ==== hw/asfl_defines.svh ====
// Offsets, field positions, reset values and operation control fields of the flag block
`ifndef ASFL_DEFINES_SVH
`define ASFL_DEFINES_SVH

// ****************************************
// Register map (word aligned byte addresses)
// ****************************************
`define ASFL_OFS_MAIN 4'h0
`define ASFL_OFS_ALT 4'h4
`define ASFL_OFS_OPCTL 4'h8
`define ASFL_OFS_OPERAND 4'hc

// ****************************************
// Flag bit positions
// ****************************************
`define ASFL_BIT_S 7
`define ASFL_BIT_Z 6
`define ASFL_BIT_H 4
`define ASFL_BIT_PV 2
`define ASFL_BIT_N 1
`define ASFL_BIT_C 0
`define ASFL_FLAG_MASK 8'hd7

// ****************************************
// Reset values
// ****************************************
`define ASFL_FLAGS_RST 8'h00

// ****************************************
// Operation control fields
// ****************************************
`define ASFL_OPCTL_OP_LSB 0
`define ASFL_OPCTL_OP_MSB 4
`define ASFL_OPCTL_BITSEL_LSB 8
`define ASFL_OPCTL_BITSEL_MSB 10
`define ASFL_OPCTL_IEC 12
`define ASFL_OPCTL_CNTZ 13
`define ASFL_OPCTL_DAAC 14
`define ASFL_OPCTL_SWAP 15

`endif

// ==== hw/asfl_pkg.sv ====
// Types shared by the flag block
package asfl_pkg;

  typedef enum logic [4:0] {
    ASFL_OP_NONE,
    ASFL_OP_ADD,
    ASFL_OP_ADC,
    ASFL_OP_SUB,
    ASFL_OP_SBC,
    ASFL_OP_CMP,
    ASFL_OP_AND,
    ASFL_OP_OR,
    ASFL_OP_XOR,
    ASFL_OP_ROT_LEFT_CIRC,
    ASFL_OP_ROT_RIGHT_CIRC,
    ASFL_OP_RL,
    ASFL_OP_RR,
    ASFL_OP_SHIFT_LEFT_ARITH,
    ASFL_OP_SHIFT_RIGHT_ARITH,
    ASFL_OP_SHIFT_RIGHT_LOG,
    ASFL_OP_DEC_ADJUST,
    ASFL_OP_SET_CARRY,
    ASFL_OP_CPL_CARRY,
    ASFL_OP_BIT,
    ASFL_OP_BLKXFER,
    ASFL_OP_BLKSRCH,
    ASFL_OP_BLKIO,
    ASFL_OP_PORTIN,
    ASFL_OP_LDIRQ
  } asfl_op_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic und5;
    logic half;
    logic und3;
    logic par_ovf;
    logic sub;
    logic carry;
  } asfl_flags_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } asfl_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } asfl_wb_rsp_t;

  typedef struct packed {
    logic c;
    logic pv;
    logic z;
    logic s;
  } asfl_cond_t;

endpackage

// ==== verification/tb_top.sv ====
// Self-checking bench for the status flag block
`timescale 1ns/1ps
module tb_top;
  import asfl_pkg::*;
  typedef struct packed {
    logic [7:0] fin;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] ctl;
    logic [7:0] exp;
    logic [7:0] mask;
    logic [7:0] res;
    logic chk;
  } asfl_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  asfl_wb_req_t req = '0;
  asfl_wb_rsp_t rsp;
  asfl_cond_t cond;
  logic [7:0] res;
  asfl_row_t rows[$];
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic [7:0] cf;

  always #2 clk_i = ~clk_i;

  asfl_core asfl_core_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .cond_o(cond),
    .result_o(res)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
      begin
        $display("NO MISMATCHES");
      end
      else
      begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    begin
      n_compared++;
      if ((got & mask) !== (exp & mask))
      begin
        n_errors++;
        $display("Error at %0t: got %h expected %h", $time, got & mask, exp & mask);
      end
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic [3:0] adr, input logic we, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: adr, dat: wd};
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (rsp.ack !== 1'b1 && n < 20);
      if (rsp.ack !== 1'b1)
      begin
        n_errors++;
        $display("Error at %0t: ack got %h expected %h", $time, rsp.ack, 1'b1);
        report_and_stop();
      end
      rdat = rsp.dat;
      req <= '0;
    end
  endtask

  task automatic row(input logic [7:0] fin, a, b, input logic [15:0] ctl, input logic [7:0] exp, mask, r,
                     input logic c);
    begin
      rows.push_back('{fin, a, b, ctl, exp, mask, r, c});
    end
  endtask

  task automatic op(input logic [15:0] ctl);
    begin
      wb(4'h8, 1'b1, {16'h0, ctl}, rd);
      repeat (2) @(posedge clk_i);
    end
  endtask

  task automatic run_row(input asfl_row_t r);
    begin
      wb(4'h0, 1'b1, {24'h0, r.fin}, rd);
      wb(4'hc, 1'b1, {16'h0, r.b, r.a}, rd);
      op(r.ctl);
      wb(4'h0, 1'b0, 32'h0, rd);
      chk(rd, {24'h0, r.exp}, {24'hffffff, r.mask});
      cf = {cond.s, cond.z, 3'b000, cond.pv, 1'b0, cond.c};
      chk({24'h0, cf}, {24'h0, r.exp}, {24'h0, r.mask & 8'hc5});
      chk({24'h0, res}, {24'h0, r.res}, {24'h0, {8{r.chk}}});
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    row(8'h00, 8'h78, 8'h69, 16'h0001, 8'h94, 8'hd7, 8'he1, 1'b1);
    row(8'h00, 8'hff, 8'h01, 16'h0001, 8'h51, 8'hd7, 8'h00, 1'b1);
    row(8'h01, 8'h0e, 8'h01, 16'h0002, 8'h10, 8'hd7, 8'h10, 1'b1);
    row(8'h00, 8'h7f, 8'hc0, 16'h0003, 8'h87, 8'hd7, 8'hbf, 1'b1);
    row(8'h00, 8'h01, 8'h02, 16'h0003, 8'h93, 8'hd7, 8'hff, 1'b1);
    row(8'h01, 8'h10, 8'h00, 16'h0004, 8'h12, 8'hd7, 8'h0f, 1'b1);
    row(8'h00, 8'h42, 8'h42, 16'h0005, 8'h42, 8'hd7, 8'h00, 1'b0);
    row(8'h01, 8'hf0, 8'h0f, 16'h0006, 8'h54, 8'hd7, 8'h00, 1'b1);
    row(8'h01, 8'h01, 8'h02, 16'h0007, 8'h04, 8'hd7, 8'h03, 1'b1);
    row(8'h01, 8'h80, 8'h00, 16'h0008, 8'h80, 8'hd7, 8'h80, 1'b1);
    row(8'h00, 8'h81, 8'h00, 16'h0009, 8'h05, 8'h05, 8'h03, 1'b1);
    row(8'h00, 8'h01, 8'h00, 16'h000a, 8'h01, 8'h05, 8'h80, 1'b1);
    row(8'h01, 8'h00, 8'h00, 16'h000b, 8'h00, 8'h05, 8'h01, 1'b1);
    row(8'h00, 8'h80, 8'h00, 16'h000b, 8'h05, 8'h05, 8'h00, 1'b1);
    row(8'h01, 8'h00, 8'h00, 16'h000c, 8'h00, 8'h05, 8'h80, 1'b1);
    row(8'h00, 8'hc0, 8'h00, 16'h000d, 8'h01, 8'h05, 8'h80, 1'b1);
    row(8'h00, 8'h81, 8'h00, 16'h000e, 8'h05, 8'h05, 8'hc0, 1'b1);
    row(8'h00, 8'h81, 8'h00, 16'h000f, 8'h01, 8'h05, 8'h40, 1'b1);
    row(8'h00, 8'h9a, 8'h00, 16'h0010, 8'h01, 8'h01, 8'h00, 1'b1);
    row(8'h00, 8'h12, 8'h00, 16'h0010, 8'h00, 8'h01, 8'h12, 1'b1);
    row(8'h00, 8'h12, 8'h00, 16'h4010, 8'h01, 8'h01, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h0011, 8'h01, 8'h01, 8'h00, 1'b0);
    row(8'h01, 8'h00, 8'h00, 16'h0012, 8'h00, 8'h01, 8'h00, 1'b0);
    row(8'h00, 8'hf7, 8'hf7, 16'h0313, 8'h40, 8'h40, 8'h00, 1'b0);
    row(8'h00, 8'h80, 8'h80, 16'h0713, 8'h00, 8'h40, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h2014, 8'h00, 8'h04, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h0014, 8'h04, 8'h04, 8'h00, 1'b0);
    row(8'h00, 8'h33, 8'h33, 16'h2015, 8'h42, 8'hd6, 8'h00, 1'b0);
    row(8'h00, 8'h33, 8'h34, 16'h0015, 8'h96, 8'hd6, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h2016, 8'h40, 8'h40, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h0016, 8'h00, 8'h40, 8'h00, 1'b0);
    row(8'h00, 8'h83, 8'h83, 16'h0017, 8'h80, 8'hc4, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h0017, 8'h44, 8'hc4, 8'h00, 1'b0);
    row(8'h00, 8'h00, 8'h00, 16'h1018, 8'h04, 8'h04, 8'h00, 1'b0);
    row(8'h04, 8'h00, 8'h00, 16'h0018, 8'h00, 8'h04, 8'h00, 1'b0);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({20'h0, cond, res}, 32'h0, 32'hfff);
    wb(4'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, 32'hffffffff);
    wb(4'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, 32'hffffffff);
    $display("reset test done");
    foreach (rows[i])
    begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Unused bits and unmapped address
    wb(4'h0, 1'b1, 32'hffffffff, rd);
    wb(4'h4, 1'b1, 32'h000000ff, rd);
    wb(4'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'hd7, 32'hffffffff);
    wb(4'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'hd7, 32'hffffffff);
    wb(4'h2, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, 32'hffffffff);
    $display("mask test done");
    // Swap, then an op touches only the main byte
    wb(4'h0, 1'b1, 32'h01, rd);
    wb(4'h4, 1'b1, 32'h80, rd);
    op(16'h8000);
    wb(4'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'h80, 32'hffffffff);
    wb(4'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'h01, 32'hffffffff);
    op(16'h0011);
    wb(4'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'h81, 32'hffffffff);
    wb(4'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'h01, 32'hffffffff);
    $display("swap test done");
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h0, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, 32'hffffffff);
    chk({20'h0, cond, res}, 32'h0, 32'hfff);
    wb(4'h4, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, 32'hffffffff);
    $display("second reset test done");
    report_and_stop();
  end
endmodule // tb_top
